// File: rtl/dlt_decoder.sv
// display list tag and vertex command decoder with graphics context
//
// Contract
// - tag command sets 8-bit tag value
// - tag value starts at 255
// - clear-tag default takes effect on clear
// - drawn objects carry current tag unless masked
// - touch loads touched object's tag
// - no tag command means objects report 255
// - mask one selects tag command value
// - mask zero selects default tag value
// - clear without clear-tag gives default zero
// - tag and mask saved in context
// - fractional vertex: kind 1, signed 15-bit X/Y
// - vertex format sets fraction, initially four
// - fractional coordinates scaled by fraction bits
// - integer vertex: 9-bit X/Y, handle, cell
// - handle and cell only for bitmap primitive
// - x offset added to both vertex kinds
// - y offset added to both vertex kinds
// - fraction, offsets in context; vertices change none
// - restore on empty stack loads defaults
`timescale 1ns/1ps
module dlt_decoder
    import dlt_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                cmd_valid,
    input  wire logic [31:0]         cmd_word,
    output logic                     cmd_ready,
    input  wire logic                touch_valid,
    input  wire logic [TAG_W-1:0]    touch_obj_tag,
    output logic      [TAG_W-1:0]    touch_tag,
    output logic                     vertex_valid,
    output logic signed [COORD_W-1:0] vertex_x,
    output logic signed [COORD_W-1:0] vertex_y,
    output logic      [HANDLE_W-1:0] vertex_handle,
    output logic      [CELL_W-1:0]   vertex_cell,
    output logic                     vertex_bitmap,
    output logic      [TAG_W-1:0]    vertex_tag,
    output logic      [TAG_W-1:0]    tag_value,
    output logic                     tag_mask,
    output logic      [FRAC_W-1:0]   frac,
    output logic      [OFF_W-1:0]    x_offset,
    output logic      [OFF_W-1:0]    y_offset,
    output logic      [TAG_W-1:0]    clear_tag_value,
    output logic      [TAG_W-1:0]    live_default_tag,
    output logic      [PRIM_W-1:0]   prim
);
    // opcode match on bits 31:24, lower field bits are not looked at
    function automatic logic is_op(input logic [31:0] w, input logic [7:0] op);
        return w[OPC_MSB:OPC_LSB] == op;
    endfunction

    // signed coordinate scaled to sixteenths of a pixel
    function automatic logic signed [COORD_W-1:0] scale_fv(
        input logic [FV_W-1:0]   c,
        input logic [FRAC_W-1:0] f
    );
        logic signed [COORD_W-1:0] ext;
        logic [FRAC_W-1:0]         sh;
        ext = COORD_W'(signed'(c));
        sh  = (f > FRAC_MAX) ? 3'h0 : (FRAC_MAX - f);
        return ext <<< sh;
    endfunction

    // signed offset widened to coordinate width
    function automatic logic signed [COORD_W-1:0] ext_off(input logic [OFF_W-1:0] o);
        return COORD_W'(signed'(o));
    endfunction

    logic                     is_fvertex;
    logic                     is_ivertex;
    logic                     is_opcmd;
    logic                     do_tag;
    logic                     do_mask;
    logic                     do_format;
    logic                     do_xoff;
    logic                     do_yoff;
    logic                     do_save;
    logic                     do_restore;
    logic                     do_begin;
    logic                     do_clear_tag;
    logic                     do_clear;
    logic [CTX_W-1:0]         ctx_now;
    logic [CTX_W-1:0]         ctx_top;
    logic [CTX_W-1:0]         ctx_load;
    logic                     stack_empty;
    logic [TAG_W-1:0]         obj_tag;

    logic [TAG_W-1:0]         next_tag_value;
    logic                     next_tag_mask;
    logic [FRAC_W-1:0]        next_frac;
    logic [OFF_W-1:0]         next_x_offset;
    logic [OFF_W-1:0]         next_y_offset;
    logic [TAG_W-1:0]         next_clear_tag_value;
    logic [TAG_W-1:0]         next_live_default_tag;
    logic [PRIM_W-1:0]        next_prim;

    logic                     next_vertex_valid;
    logic signed [COORD_W-1:0] next_vertex_x;
    logic signed [COORD_W-1:0] next_vertex_y;
    logic [HANDLE_W-1:0]      next_vertex_handle;
    logic [CELL_W-1:0]        next_vertex_cell;
    logic                     next_vertex_bitmap;
    logic [TAG_W-1:0]         next_vertex_tag;

    // one word per cycle, never stalls
    assign cmd_ready = 1'b1;

    // command decode
    assign is_fvertex   = cmd_valid && cmd_word[KIND_MSB:KIND_LSB] == KIND_FVERTEX;
    assign is_ivertex   = cmd_valid && cmd_word[KIND_MSB:KIND_LSB] == KIND_IVERTEX;
    assign is_opcmd     = cmd_valid && cmd_word[KIND_MSB:KIND_LSB] == 2'h0;
    assign do_tag       = is_opcmd && is_op(cmd_word, OP_TAG);
    assign do_mask      = is_opcmd && is_op(cmd_word, OP_TAG_MASK);
    assign do_format    = is_opcmd && is_op(cmd_word, OP_VTX_FORMAT);
    assign do_xoff      = is_opcmd && is_op(cmd_word, OP_X_OFFSET);
    assign do_yoff      = is_opcmd && is_op(cmd_word, OP_Y_OFFSET);
    assign do_save      = is_opcmd && is_op(cmd_word, OP_SAVE);
    assign do_restore   = is_opcmd && is_op(cmd_word, OP_RESTORE);
    assign do_begin     = is_opcmd && is_op(cmd_word, OP_BEGIN);
    assign do_clear_tag = is_opcmd && is_op(cmd_word, OP_CLEAR_TAG);
    assign do_clear     = is_opcmd && is_op(cmd_word, OP_CLEAR);

    // current context packed for the stack
    assign ctx_now = {tag_value, tag_mask, frac, x_offset, y_offset};

    // empty stack restores the power-up context
    assign ctx_load = stack_empty ? CTX_DEFAULT : ctx_top;

    // tag attached to objects drawn now
    assign obj_tag = tag_mask ? tag_value : live_default_tag;

    // graphics state update
    always_comb begin
        next_tag_value        = tag_value;
        next_tag_mask         = tag_mask;
        next_frac             = frac;
        next_x_offset         = x_offset;
        next_y_offset         = y_offset;
        next_clear_tag_value  = clear_tag_value;
        next_live_default_tag = live_default_tag;
        next_prim             = prim;
        if (do_tag) begin
            next_tag_value = cmd_word[TAG_LSB +: TAG_W];
        end
        if (do_mask) begin
            next_tag_mask = cmd_word[MASK_BIT];
        end
        if (do_format) begin
            next_frac = cmd_word[FRAC_LSB +: FRAC_W];
        end
        if (do_xoff) begin
            next_x_offset = cmd_word[OFF_LSB +: OFF_W];
        end
        if (do_yoff) begin
            next_y_offset = cmd_word[OFF_LSB +: OFF_W];
        end
        if (do_begin) begin
            next_prim = cmd_word[PRIM_LSB +: PRIM_W];
        end
        if (do_clear_tag) begin
            next_clear_tag_value = cmd_word[TAG_LSB +: TAG_W];
        end
        if (do_clear) begin
            next_live_default_tag = clear_tag_value;
        end
        if (do_restore) begin
            {next_tag_value, next_tag_mask, next_frac,
             next_x_offset, next_y_offset} = ctx_load;
        end
    end

    // state registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tag_value        <= TAG_RESET;
            tag_mask         <= MASK_RESET;
            frac             <= FRAC_RESET;
            x_offset         <= OFF_RESET;
            y_offset         <= OFF_RESET;
            clear_tag_value  <= CLEAR_TAG_RESET;
            live_default_tag <= LIVE_DEFAULT_INIT;
            prim             <= PRIM_RESET;
        end else begin
            tag_value        <= next_tag_value;
            tag_mask         <= next_tag_mask;
            frac             <= next_frac;
            x_offset         <= next_x_offset;
            y_offset         <= next_y_offset;
            clear_tag_value  <= next_clear_tag_value;
            live_default_tag <= next_live_default_tag;
            prim             <= next_prim;
        end
    end

    // vertex output, coordinates in sixteenths of a pixel
    always_comb begin
        next_vertex_valid  = 1'b0;
        next_vertex_x      = vertex_x;
        next_vertex_y      = vertex_y;
        next_vertex_handle = vertex_handle;
        next_vertex_cell   = vertex_cell;
        next_vertex_bitmap = vertex_bitmap;
        next_vertex_tag    = vertex_tag;
        if (is_fvertex) begin
            next_vertex_valid  = 1'b1;
            next_vertex_x      = scale_fv(cmd_word[FV_X_LSB +: FV_W], frac)
                                 + ext_off(x_offset);
            next_vertex_y      = scale_fv(cmd_word[FV_Y_LSB +: FV_W], frac)
                                 + ext_off(y_offset);
            next_vertex_handle = '0;
            next_vertex_cell   = '0;
            next_vertex_bitmap = 1'b0;
            next_vertex_tag    = obj_tag;
        end else if (is_ivertex) begin
            next_vertex_valid  = 1'b1;
            next_vertex_x      = COORD_W'({cmd_word[IV_X_LSB +: IV_W], 4'h0})
                                 + ext_off(x_offset);
            next_vertex_y      = COORD_W'({cmd_word[IV_Y_LSB +: IV_W], 4'h0})
                                 + ext_off(y_offset);
            next_vertex_bitmap = (prim == PRIM_BITMAP);
            if (prim == PRIM_BITMAP) begin
                next_vertex_handle = cmd_word[IV_HANDLE_LSB +: HANDLE_W];
                next_vertex_cell   = cmd_word[IV_CELL_LSB +: CELL_W];
            end else begin
                next_vertex_handle = '0;
                next_vertex_cell   = '0;
            end
            next_vertex_tag    = obj_tag;
        end
    end

    // vertex registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            vertex_valid  <= 1'b0;
            vertex_x      <= '0;
            vertex_y      <= '0;
            vertex_handle <= '0;
            vertex_cell   <= '0;
            vertex_bitmap <= 1'b0;
            vertex_tag    <= TAG_RESET;
        end else begin
            vertex_valid  <= next_vertex_valid;
            vertex_x      <= next_vertex_x;
            vertex_y      <= next_vertex_y;
            vertex_handle <= next_vertex_handle;
            vertex_cell   <= next_vertex_cell;
            vertex_bitmap <= next_vertex_bitmap;
            vertex_tag    <= next_vertex_tag;
        end
    end

    // context save and restore stack
    dlt_context_stack u_stack (
        .ref_clk (ref_clk),
        .reset   (reset),
        .push    (do_save),
        .pop     (do_restore),
        .ctx_in  (ctx_now),
        .ctx_top (ctx_top),
        .empty   (stack_empty)
    );

    // touch tag report
    dlt_touch_tag u_touch (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .touch_valid   (touch_valid),
        .touch_obj_tag (touch_obj_tag),
        .touch_tag     (touch_tag)
    );
endmodule

// File: include/dlt_pkg.sv
// constants shared by the display list tag and vertex decoder
package dlt_pkg;
    // command word layout
    localparam int OPC_MSB  = 31;
    localparam int OPC_LSB  = 24;
    localparam int KIND_MSB = 31;
    localparam int KIND_LSB = 30;

    // opcodes of the bits 31:24 commands
    localparam logic [7:0] OP_TAG        = 8'h03;
    localparam logic [7:0] OP_TAG_MASK   = 8'h14;
    localparam logic [7:0] OP_VTX_FORMAT = 8'h27;
    localparam logic [7:0] OP_X_OFFSET   = 8'h2B;
    localparam logic [7:0] OP_Y_OFFSET   = 8'h2C;
    localparam logic [7:0] OP_SAVE       = 8'h22;
    localparam logic [7:0] OP_RESTORE    = 8'h23;
    localparam logic [7:0] OP_BEGIN      = 8'h30;
    localparam logic [7:0] OP_CLEAR_TAG  = 8'h31;
    localparam logic [7:0] OP_CLEAR      = 8'h32;

    // vertex kinds in bits 31:30
    localparam logic [1:0] KIND_FVERTEX = 2'h1;
    localparam logic [1:0] KIND_IVERTEX = 2'h2;

    // field positions and widths
    localparam int TAG_LSB       = 0;
    localparam int TAG_W         = 8;
    localparam int MASK_BIT      = 0;
    localparam int FRAC_LSB      = 0;
    localparam int FRAC_W        = 3;
    localparam int OFF_LSB       = 0;
    localparam int OFF_W         = 17;
    localparam int PRIM_LSB      = 0;
    localparam int PRIM_W        = 4;
    localparam int FV_X_LSB      = 15;
    localparam int FV_Y_LSB      = 0;
    localparam int FV_W          = 15;
    localparam int IV_X_LSB      = 21;
    localparam int IV_Y_LSB      = 12;
    localparam int IV_W          = 9;
    localparam int IV_HANDLE_LSB = 7;
    localparam int HANDLE_W      = 5;
    localparam int IV_CELL_LSB   = 0;
    localparam int CELL_W        = 7;
    localparam int COORD_W       = 20;
    localparam int SUBPIX_BITS   = 4;

    // reset and default values
    localparam logic [TAG_W-1:0]  TAG_RESET         = 8'hFF;
    localparam logic              MASK_RESET        = 1'b1;
    localparam logic [FRAC_W-1:0] FRAC_RESET        = 3'h4;
    localparam logic [FRAC_W-1:0] FRAC_MAX          = 3'h4;
    localparam logic [OFF_W-1:0]  OFF_RESET         = 17'h00000;
    localparam logic [TAG_W-1:0]  CLEAR_TAG_RESET   = 8'h00;
    localparam logic [TAG_W-1:0]  LIVE_DEFAULT_INIT = 8'hFF;
    localparam logic [TAG_W-1:0]  TOUCH_TAG_RESET   = 8'h00;
    localparam logic [PRIM_W-1:0] PRIM_RESET        = 4'h0;
    localparam logic [PRIM_W-1:0] PRIM_BITMAP       = 4'h1;

    // saved graphics context: tag, mask, frac, x offset, y offset
    localparam int CTX_W       = TAG_W + 1 + FRAC_W + OFF_W + OFF_W;
    localparam int STACK_DEPTH = 4;
    localparam int COUNT_W     = 3;
    localparam logic [CTX_W-1:0] CTX_DEFAULT =
        {TAG_RESET, MASK_RESET, FRAC_RESET, OFF_RESET, OFF_RESET};
endpackage

// File: rtl/dlt_context_stack.sv
// four level graphics context stack, oldest entry dropped on overflow
`timescale 1ns/1ps
module dlt_context_stack
    import dlt_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [CTX_W-1:0] ctx_in,
    output logic      [CTX_W-1:0] ctx_top,
    output logic                  empty
);
    logic [CTX_W-1:0]   entry      [STACK_DEPTH];
    logic [CTX_W-1:0]   next_entry [STACK_DEPTH];
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;

    // push shifts up and saturates, pop shifts down
    always_comb begin
        for (int i = 0; i < STACK_DEPTH; i++) begin
            next_entry[i] = entry[i];
        end
        next_count = count;
        if (push) begin
            for (int i = STACK_DEPTH - 1; i > 0; i--) begin
                next_entry[i] = entry[i-1];
            end
            next_entry[0] = ctx_in;
            if (count != COUNT_W'(STACK_DEPTH)) begin
                next_count = count + 3'h1;
            end
        end else if (pop && count != 3'h0) begin
            for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                next_entry[i] = entry[i+1];
            end
            next_entry[STACK_DEPTH-1] = CTX_DEFAULT;
            next_count = count - 3'h1;
        end
    end

    // stack registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                entry[i] <= CTX_DEFAULT;
            end
            count <= 3'h0;
        end else begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                entry[i] <= next_entry[i];
            end
            count <= next_count;
        end
    end

    assign ctx_top = entry[0];
    assign empty   = (count == 3'h0);
endmodule

// File: rtl/dlt_touch_tag.sv
// touch tag register, loaded with the tag of a touched object
`timescale 1ns/1ps
module dlt_touch_tag
    import dlt_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             touch_valid,
    input  wire logic [TAG_W-1:0] touch_obj_tag,
    output logic      [TAG_W-1:0] touch_tag
);
    logic [TAG_W-1:0] next_touch_tag;

    // take the tag of the object under the touch
    always_comb begin
        next_touch_tag = touch_tag;
        if (touch_valid) begin
            next_touch_tag = touch_obj_tag;
        end
    end

    // register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            touch_tag <= TOUCH_TAG_RESET;
        end else begin
            touch_tag <= next_touch_tag;
        end
    end
endmodule

// File: tb/dlt_decoder_chk.sv
// port checker for the tag and vertex decoder
`timescale 1ns/1ps
module dlt_decoder_chk
    import dlt_pkg::*;
(
    input wire logic               ref_clk,
    input wire logic               reset,
    input wire logic               cmd_valid,
    input wire logic [31:0]        cmd_word,
    input wire logic               touch_valid,
    input wire logic [7:0]         touch_obj_tag,
    input wire logic [7:0]         touch_tag,
    input wire logic               vertex_valid,
    input wire logic signed [19:0] vertex_x,
    input wire logic signed [19:0] vertex_y,
    input wire logic [4:0]         vertex_handle,
    input wire logic [6:0]         vertex_cell,
    input wire logic               vertex_bitmap,
    input wire logic [7:0]         vertex_tag,
    input wire logic [7:0]         tag_value,
    input wire logic               tag_mask,
    input wire logic [2:0]         frac,
    input wire logic [16:0]        x_offset,
    input wire logic [16:0]        y_offset,
    input wire logic [7:0]         clear_tag_value,
    input wire logic [7:0]         live_default_tag,
    input wire logic [3:0]         prim
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // decoded strobes
    wire [7:0] op    = cmd_word[31:24];
    wire       is_fv = cmd_valid && cmd_word[31:30] == KIND_FVERTEX;
    wire       is_iv = cmd_valid && cmd_word[31:30] == KIND_IVERTEX;
    // expected coordinates in sixteenths of a pixel
    function automatic logic signed [19:0] fv_c(logic [14:0] v, logic [2:0] f, logic [16:0] o);
        logic signed [19:0] s;
        s = {{5{v[14]}}, v};
        s = s <<< ((f > 3'h4) ? 3'h0 : 3'h4 - f);
        return s + {{3{o[16]}}, o};
    endfunction
    function automatic logic signed [19:0] iv_c(logic [8:0] v, logic [16:0] o);
        return {7'h00, v, 4'h0} + {{3{o[16]}}, o};
    endfunction
    // expectations captured with each word
    logic [31:0]        w_q;
    logic [7:0]         et_q;
    logic signed [19:0] ex_q;
    logic signed [19:0] ey_q;
    always_ff @(posedge ref_clk) begin
        w_q  <= cmd_word;
        et_q <= tag_mask ? tag_value : live_default_tag;
        ex_q <= cmd_word[31] ? iv_c(cmd_word[29:21], x_offset)
                             : fv_c(cmd_word[29:15], frac, x_offset);
        ey_q <= cmd_word[31] ? iv_c(cmd_word[20:12], y_offset)
                             : fv_c(cmd_word[14:0], frac, y_offset);
    end
    property p_tag_set; cmd_valid && op == OP_TAG |=> tag_value == w_q[7:0]; endproperty
    a_tag_set: assert property (p_tag_set) else $error("tag not loaded");
    property p_mask_set; cmd_valid && op == OP_TAG_MASK |=> tag_mask == w_q[0]; endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask not loaded");
    property p_frac_set; cmd_valid && op == OP_VTX_FORMAT |=> frac == w_q[2:0]; endproperty
    a_frac_set: assert property (p_frac_set) else $error("frac not loaded");
    property p_vtx_tag; is_fv || is_iv |=> vertex_valid && vertex_tag == et_q; endproperty
    a_vtx_tag: assert property (p_vtx_tag) else $error("vertex tag wrong");
    property p_fv_pos; is_fv
        |=> vertex_x == ex_q && vertex_y == ey_q && vertex_cell == 7'h00; endproperty
    a_fv_pos: assert property (p_fv_pos) else $error("fv pos wrong");
    property p_iv_pos; is_iv |=> vertex_x == ex_q && vertex_y == ey_q; endproperty
    a_iv_pos: assert property (p_iv_pos) else $error("int vertex wrong");
    property p_iv_bmp; is_iv && prim == PRIM_BITMAP
        |=> vertex_bitmap && {vertex_handle, vertex_cell} == w_q[11:0]; endproperty
    a_iv_bmp: assert property (p_iv_bmp) else $error("handle or cell lost");
    property p_iv_plain; is_iv && prim != PRIM_BITMAP
        |=> !vertex_bitmap && vertex_handle == 5'h00 && vertex_cell == 7'h00; endproperty
    a_iv_plain: assert property (p_iv_plain) else $error("handle not ignored");
    property p_vv_pulse; !(is_fv || is_iv) |=> !vertex_valid; endproperty
    a_vv_pulse: assert property (p_vv_pulse) else $error("stray vertex pulse");
    property p_vtx_ctx;
        is_fv || is_iv |=> $stable({tag_value, tag_mask, frac, x_offset, y_offset}); endproperty
    a_vtx_ctx: assert property (p_vtx_ctx) else $error("vertex changed state");
    property p_touch; touch_valid |=> touch_tag == $past(touch_obj_tag); endproperty
    a_touch: assert property (p_touch) else $error("touch tag wrong");
    property p_clear; cmd_valid && op == OP_CLEAR |=> live_default_tag == $past(clear_tag_value);
    endproperty
    a_clear: assert property (p_clear) else $error("default not taken");
endmodule

bind dlt_decoder dlt_decoder_chk u_chk (
    .ref_clk, .reset, .cmd_valid, .cmd_word, .touch_valid, .touch_obj_tag, .touch_tag,
    .vertex_valid, .vertex_x, .vertex_y, .vertex_handle, .vertex_cell, .vertex_bitmap,
    .vertex_tag, .tag_value, .tag_mask, .frac, .x_offset, .y_offset, .clear_tag_value,
    .live_default_tag, .prim
);

// File: tb/dlt_host_model.sv
// host model writing display list words
`timescale 1ns/1ps
module dlt_host_model
    import dlt_pkg::*;
(
    input  wire logic ref_clk,
    output logic        cmd_valid,
    output logic [31:0] cmd_word
);
    initial begin
        cmd_valid = 1'b0;
        cmd_word  = 32'h00000000;
    end
    // one word per edge; hold keeps valid up for a following word
    task automatic send(input logic [31:0] w, input bit hold);
        if (w[31:24] == OP_TAG && w[7:0] == 8'h00) w[7:0] = 8'h01;
        if (w[31:24] == OP_VTX_FORMAT && w[2:0] > FRAC_MAX) w[2:0] = FRAC_MAX;
        cmd_valid = 1'b1;
        cmd_word  = w;
        @(posedge ref_clk);
        #1;
        if (!hold) begin
            cmd_valid = 1'b0;
            cmd_word  = ~w; // released word never shows the last value
        end
    endtask
endmodule

// File: tb/dlt_decoder_tb.sv
// self-checking bench for the tag and vertex decoder
`timescale 1ns/1ps
module dlt_decoder_tb;
    typedef struct { logic [31:0] w; int sel; logic [31:0] e; } dlt_row_t;
    logic               ref_clk;
    logic               reset;
    logic               touch_valid;
    logic [7:0]         touch_obj_tag;
    logic               cmd_valid;
    logic [31:0]        cmd_word;
    logic               cmd_ready;
    logic [7:0]         touch_tag;
    logic               vertex_valid;
    logic signed [19:0] vertex_x;
    logic signed [19:0] vertex_y;
    logic [4:0]         vertex_handle;
    logic [6:0]         vertex_cell;
    logic               vertex_bitmap;
    logic [7:0]         vertex_tag;
    logic [7:0]         tag_value;
    logic               tag_mask;
    logic [2:0]         frac;
    logic [16:0]        x_offset;
    logic [16:0]        y_offset;
    logic [7:0]         clear_tag_value;
    logic [7:0]         live_default_tag;
    logic [3:0]         prim;
    int                 fail_count = 0;
    int                 tests_run = 0;
    int                 cycles = 0;
    // sel: 0 tag 1 mask 2 frac 3 xoff 4 yoff 5 vx 6 vy 7 vtag 8 handle 9 cell
    // 10 default 11 prim 12 cleartag 13 touch 14 valid 15 bitmap 16 ready
    logic [31:0] rst_exp [0:16] = '{32'hFF, 32'h1, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0,
        32'hFF, 32'h0, 32'h0, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
    dlt_row_t rows [0:30] = '{
        '{32'h40008001, 7, 32'hFF},
        '{32'h03ABCD2A, 0, 32'h2A},
        '{32'h40008001, 7, 32'h2A},
        '{32'h14FFFFFE, 1, 32'h0},
        '{32'h40008001, 7, 32'hFF},
        '{32'h32000000, 10, 32'h0},
        '{32'h40008001, 7, 32'h0},
        '{32'h31000077, 10, 32'h0},
        '{32'h32ABCDEF, 10, 32'h77},
        '{32'h14000001, 1, 32'h1},
        '{32'h40008001, 7, 32'h2A},
        '{32'h27000000, 2, 32'h0},
        '{32'h7FFF8000, 5, 32'hFFFF0},
        '{32'h27FFFFFA, 2, 32'h2},
        '{32'h40000003, 6, 32'hC},
        '{32'h2B000010, 3, 32'h10},
        '{32'h2C01FFFF, 4, 32'h1FFFF},
        '{32'h40008000, 5, 32'h14},
        '{32'h40000003, 6, 32'hB},
        '{32'h80A07189, 5, 32'h60},
        '{32'h80A07189, 6, 32'h6F},
        '{32'h80A07189, 8, 32'h0},
        '{32'h30000001, 11, 32'h1},
        '{32'h80A07189, 8, 32'h3},
        '{32'h80A07189, 9, 32'h9},
        '{32'h22000000, 0, 32'h2A},
        '{32'h03000055, 0, 32'h55},
        '{32'h27000004, 2, 32'h4},
        '{32'h23000000, 2, 32'h2},
        '{32'h23000000, 0, 32'hFF},
        '{32'h23000000, 3, 32'h0}};

    dlt_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
    dlt_decoder uut (
        .ref_clk, .reset, .cmd_valid, .cmd_word, .cmd_ready, .touch_valid, .touch_obj_tag,
        .touch_tag, .vertex_valid, .vertex_x, .vertex_y, .vertex_handle, .vertex_cell,
        .vertex_bitmap, .vertex_tag, .tag_value, .tag_mask, .frac, .x_offset, .y_offset,
        .clear_tag_value, .live_default_tag, .prim);

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // output selected by row code
    function automatic logic [31:0] pick(input int s);
        case (s)
            0: return 32'(tag_value);
            1: return 32'(tag_mask);
            2: return 32'(frac);
            3: return 32'(x_offset);
            4: return 32'(y_offset);
            5: return {12'h000, vertex_x};
            6: return {12'h000, vertex_y};
            7: return 32'(vertex_tag);
            8: return 32'(vertex_handle);
            9: return 32'(vertex_cell);
            10: return 32'(live_default_tag);
            11: return 32'(prim);
            12: return 32'(clear_tag_value);
            13: return 32'(touch_tag);
            14: return 32'(vertex_valid);
            15: return 32'(vertex_bitmap);
            default: return 32'(cmd_ready);
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 1000) begin
            fail_count++;
            finish_test();
        end
    end
    // main sequence
    initial begin
        reset = 1'b1;
        touch_valid = 1'b0;
        touch_obj_tag = 8'h00;
        repeat (20) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        for (int i = 0; i < 17; i++) begin
            chk($sformatf("reset %0d", i), rst_exp[i], pick(i));
        end
        for (int i = 0; i < 31; i++) begin
            host.send(rows[i].w, 1'b0);
            chk($sformatf("row %0d", i), rows[i].e, pick(rows[i].sel));
            @(posedge ref_clk);
            #1;
        end
        // back to back tag and vertex
        host.send(32'h03000066, 1'b1);
        host.send(32'h40008001, 1'b0);
        chk("vertex_tag", 32'h66, pick(7));
        chk("vertex_valid", 32'h1, pick(14));
        chk("vertex_x", 32'h1, pick(5));
        @(posedge ref_clk);
        #1;
        chk("vertex_valid", 32'h0, pick(14));
        // unused kind and unknown opcode
        host.send(32'hC0000123, 1'b1);
        host.send(32'h3F000012, 1'b0);
        chk("tag_value", 32'h66, pick(0));
        chk("vertex_valid", 32'h0, pick(14));
        // touch of the object just drawn
        touch_valid = 1'b1;
        touch_obj_tag = vertex_tag;
        @(posedge ref_clk);
        #1;
        touch_valid = 1'b0;
        touch_obj_tag = 8'hA5;
        chk("touch_tag", 32'h66, pick(13));
        // reset in mid run
        reset = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        chk("tag_value", 32'hFF, pick(0));
        chk("live_default_tag", 32'hFF, pick(10));
        chk("touch_tag", 32'h0, pick(13));
        finish_test();
    end
endmodule
